// ### hdl/scccr_regs.sv
// channel config register bank with management serial slave
// Notes on behaviour
// - pll code maps to 4x..25x; 0000,0001,1001,1111 reserved
// - pll code in low nibble of word 1, resets 1101, rate sense overrides
// - word 2 bits 12:8 hold post-cursor weight, reset zero
// - post-cursor: sign bit plus four magnitude bits of 2.5 percent
// - word 2 bits 7:4 hold pre-cursor weight, reset zero
// - pre-cursor: sign bit plus three magnitude bits of 2.5 percent
// - word 2 bits 3:0 select swing, reset 1010, monotonic levels
// - loss-of-sync policy in word 3 bits 12:11 acts only with alignment on
// - word 3 bit 7 enables alignment, reset on, forced on in verify
// - policy 00 (reset) uses standard hysteresis to lose sync
// - policy 01: one code or disparity error drops sync at once
// - policy 10: two consecutive errors drop sync at once
// - policy 11: three consecutive errors drop sync at once
// - word 3 bit 10 picks own or partner transmit input, reset own
// - word 3 bit 9 picks own or partner receive data, reset own
// - bit 8 with no rx swap: 0 own tx clock, 1 own rx clock
// - bit 8 with rx swap: partner tx clock or partner rx clock
`timescale 1ns/1ps
`default_nettype none
module scccr_regs
   import scccr_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       mdc_i,
   input  wire logic       mdio_i,
   input  wire logic [4:0] phy_addr_i,
   input  wire logic       auto_rate_detect_i,
   input  wire logic [3:0] auto_rate_code_i,
   input  wire logic       pattern_verify_i,
   input  wire logic       code_valid_i,
   input  wire logic       code_error_i,
   input  wire logic       std_sync_lost_i,
   input  wire logic       sync_acquired_i,
   output logic            mdio_o,
   output logic            mdio_oe_n_o,
   output logic [3:0]      pll_factor_code_o,
   output logic [6:0]      pll_factor_x4_o,
   output logic            pll_code_reserved_o,
   output scccr_tx_cfg_t   tx_cfg_o,
   output scccr_route_t    route_o,
   output logic            align_enable_o,
   output logic            in_sync_o
);
   // ----------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------
   logic [2:0] mdc_sync_q;
   logic [1:0] mdio_sync_q;
   logic [4:0] phy_s1_q;
   logic [4:0] phy_s2_q;

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mdc_sync_q  <= 3'h0;
         mdio_sync_q <= 2'h3;
         phy_s1_q    <= 5'h00;
         phy_s2_q    <= 5'h00;
      end
      else
      begin
         mdc_sync_q  <= {mdc_sync_q[1:0], mdc_i};
         mdio_sync_q <= {mdio_sync_q[0], mdio_i};
         phy_s1_q    <= phy_addr_i;
         phy_s2_q    <= phy_s1_q;
      end
   end

   wire mdc_rise = mdc_sync_q[1] & ~mdc_sync_q[2];
   wire mdio_bit = mdio_sync_q[1];

   // ----------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------
   // factor times four; zero marks a reserved code
   function automatic logic [6:0] pll_x4(input logic [3:0] c);
      case (c)
         4'h2:    pll_x4 = 7'h10;
         4'h3:    pll_x4 = 7'h14;
         4'h4:    pll_x4 = 7'h18;
         4'h5:    pll_x4 = 7'h20;
         4'h6:    pll_x4 = 7'h21;
         4'h7:    pll_x4 = 7'h28;
         4'h8:    pll_x4 = 7'h30;
         4'ha:    pll_x4 = 7'h3c;
         4'hb:    pll_x4 = 7'h40;
         4'hc:    pll_x4 = 7'h42;
         4'hd:    pll_x4 = 7'h50;
         4'he:    pll_x4 = 7'h64;
         default: pll_x4 = 7'h00;
      endcase
   endfunction

   // sign-magnitude to two's complement, both negative zeros give zero
   function automatic logic signed [4:0] sm5(input logic [4:0] c);
      sm5 = c[4] ? -$signed({1'b0, c[3:0]}) : $signed({1'b0, c[3:0]});
   endfunction

   function automatic logic signed [3:0] sm4(input logic [3:0] c);
      sm4 = c[3] ? -$signed({1'b0, c[2:0]}) : $signed({1'b0, c[2:0]});
   endfunction

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   logic [3:0]  pll_code_q;
   logic [15:0] eq_q;
   logic [15:0] route_q;
   logic        wr_en;
   logic [4:0]  wr_reg;
   logic [15:0] wr_data;

   wire [3:0] pll_eff = auto_rate_detect_i ? auto_rate_code_i
                                           : pll_code_q;
   wire [15:0] eq_mask = 16'h1fff;
   wire [15:0] rt_mask = 16'h1f80;
   wire [15:0] rd_data =
      (wr_reg == REG_CTRL1)       ? {12'h000, pll_eff} :
      (wr_reg == REG_TX_EQ_SWING) ? eq_q :
      (wr_reg == REG_SYNC_ROUTE)  ? route_q : 16'h0000;

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pll_code_q <= PLL_CODE_RST;
         eq_q       <= TX_EQ_SWING_RST;
         route_q    <= SYNC_ROUTE_RST;
      end
      else if (wr_en)
      begin
         if (wr_reg == REG_CTRL1)
            pll_code_q <= wr_data[3:0];
         if (wr_reg == REG_TX_EQ_SWING)
            eq_q <= wr_data & eq_mask;
         if (wr_reg == REG_SYNC_ROUTE)
            route_q <= wr_data & rt_mask;
      end
   end

   wire [1:0] policy   = route_q[POL_MSB:POL_LSB];
   wire       align_en = route_q[ALIGN_BIT] | pattern_verify_i;

   // ----------------------------------------------------------
   // management serial slave
   // ----------------------------------------------------------
   scccr_mg_state_t st_q;
   logic [5:0]  cnt_q;
   logic [1:0]  op_q;
   logic [9:0]  addr_q;
   logic [15:0] sh_q;
   logic        drive_q;

   wire addr_hit = (addr_q[9:5] == phy_s2_q);

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         st_q        <= MG_PRE;
         cnt_q       <= 6'h00;
         op_q        <= 2'h0;
         addr_q      <= 10'h000;
         sh_q        <= 16'h0000;
         drive_q     <= 1'b0;
         mdio_o      <= 1'b1;
         mdio_oe_n_o <= 1'b1;
         wr_en       <= 1'b0;
         wr_reg      <= 5'h00;
         wr_data     <= 16'h0000;
      end
      else
      begin
         wr_en <= 1'b0;
         if (mdc_rise)
         begin
            case (st_q)
               MG_PRE:
               begin
                  mdio_oe_n_o <= 1'b1;
                  if (mdio_bit)
                     cnt_q <= (cnt_q == PREAMBLE_LEN) ? cnt_q : cnt_q + 6'h01;
                  else if (cnt_q == PREAMBLE_LEN)
                     st_q <= MG_ST;
                  else
                     cnt_q <= 6'h00;
               end
               MG_ST:
               begin
                  cnt_q <= 6'h00;
                  st_q  <= mdio_bit ? MG_OP : MG_PRE;
               end
               MG_OP:
               begin
                  op_q  <= {op_q[0], mdio_bit};
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q[0])
                  begin
                     cnt_q <= 6'h00;
                     st_q  <= MG_ADDR;
                  end
               end
               MG_ADDR:
               begin
                  addr_q <= {addr_q[8:0], mdio_bit};
                  cnt_q  <= cnt_q + 6'h01;
                  if (cnt_q[4:0] == ADDR_BITS - 5'h01)
                  begin
                     cnt_q  <= 6'h00;
                     wr_reg <= {addr_q[3:0], mdio_bit};
                     st_q   <= MG_TA;
                  end
               end
               MG_TA:
               begin
                  cnt_q <= cnt_q + 6'h01;
                  if (cnt_q == 6'h00)
                  begin
                     drive_q <= (op_q == OP_READ) && addr_hit;
                     sh_q    <= rd_data;
                     if ((op_q == OP_READ) && addr_hit)
                     begin
                        mdio_o      <= 1'b0;
                        mdio_oe_n_o <= 1'b0;
                     end
                  end
                  else
                  begin
                     cnt_q <= 6'h00;
                     st_q  <= MG_DATA;
                     if (drive_q)
                     begin
                        mdio_o <= sh_q[15];
                        sh_q   <= {sh_q[14:0], 1'b0};
                     end
                  end
               end
               MG_DATA:
               begin
                  cnt_q <= cnt_q + 6'h01;
                  if (drive_q)
                  begin
                     mdio_o <= sh_q[15];
                     sh_q   <= {sh_q[14:0], 1'b0};
                  end
                  else
                     sh_q <= {sh_q[14:0], mdio_bit};
                  if (cnt_q[4:0] == DATA_BITS - 5'h01)
                  begin
                     wr_en       <= (op_q == OP_WRITE) && addr_hit;
                     wr_data     <= {sh_q[14:0], mdio_bit};
                     drive_q     <= 1'b0;
                     mdio_o      <= 1'b1;
                     mdio_oe_n_o <= 1'b1;
                     cnt_q       <= 6'h00;
                     st_q        <= MG_PRE;
                  end
               end
               default:
                  st_q <= MG_PRE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------
   // loss-of-sync policy
   // ----------------------------------------------------------
   logic [1:0] err_run_q;
   logic       in_sync_q;

   wire [1:0] err_run_d = code_error_i ? ((err_run_q == 2'h3) ? err_run_q
                                         : err_run_q + 2'h1)
                        : (code_valid_i ? 2'h0 : err_run_q);
   wire lose_one   = (policy == POL_ONE) && (err_run_d >= 2'h1);
   wire lose_two   = (policy == POL_TWO) && (err_run_d >= 2'h2);
   wire lose_three = (policy == POL_THREE) && (err_run_d == 2'h3);
   wire lose_std   = (policy == POL_STANDARD) && std_sync_lost_i;
   wire lose_sync  = align_en & (lose_one | lose_two | lose_three
                                 | lose_std);

   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         err_run_q <= 2'h0;
         in_sync_q <= 1'b0;
      end
      else
      begin
         err_run_q <= in_sync_q ? err_run_d : 2'h0;
         if (!align_en)
            in_sync_q <= 1'b0;
         else if (in_sync_q && lose_sync)
            in_sync_q <= 1'b0;
         else if (sync_acquired_i)
            in_sync_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // registered outputs
   // ----------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pll_factor_code_o   <= PLL_CODE_RST;
         pll_factor_x4_o     <= 7'h00;
         pll_code_reserved_o <= 1'b0;
         tx_cfg_o            <= '0;
         route_o             <= '0;
         align_enable_o      <= 1'b0;
         in_sync_o           <= 1'b0;
      end
      else
      begin
         pll_factor_code_o   <= pll_eff;
         pll_factor_x4_o     <= pll_x4(pll_eff);
         pll_code_reserved_o <= (pll_x4(pll_eff) == 7'h00);
         tx_cfg_o.post_tap   <= sm5(eq_q[POST_MSB:POST_LSB]);
         tx_cfg_o.pre_tap    <= sm4(eq_q[PRE_MSB:PRE_LSB]);
         tx_cfg_o.swing      <= eq_q[SWING_MSB:SWING_LSB];
         route_o.tx_from_partner <= route_q[TXSW_BIT];
         route_o.rx_from_partner <= route_q[RXSW_BIT];
         route_o.rx_clk_partner  <= route_q[RXSW_BIT];
         route_o.rx_clk_is_rx    <= route_q[RXCK_BIT];
         align_enable_o      <= align_en;
         in_sync_o           <= in_sync_q;
      end
   end
endmodule
`default_nettype wire

// ### hdl/scccr_pkg.sv
// package: register map, field layout and types of the channel config bank
package scccr_pkg;
   // register indices on the management bus
   localparam logic [4:0]  REG_CTRL1       = 5'h01;
   localparam logic [4:0]  REG_TX_EQ_SWING = 5'h02;
   localparam logic [4:0]  REG_SYNC_ROUTE  = 5'h03;
   // reset values
   localparam logic [3:0]  PLL_CODE_RST    = 4'hd;
   localparam logic [15:0] TX_EQ_SWING_RST = 16'h000a;
   localparam logic [15:0] SYNC_ROUTE_RST  = 16'h0180;
   // field positions
   localparam int POST_LSB  = 8;
   localparam int POST_MSB  = 12;
   localparam int PRE_LSB   = 4;
   localparam int PRE_MSB   = 7;
   localparam int SWING_LSB = 0;
   localparam int SWING_MSB = 3;
   localparam int POL_LSB   = 11;
   localparam int POL_MSB   = 12;
   localparam int TXSW_BIT  = 10;
   localparam int RXSW_BIT  = 9;
   localparam int RXCK_BIT  = 8;
   localparam int ALIGN_BIT = 7;
   // loss-of-sync policies
   localparam logic [1:0]  POL_STANDARD = 2'h0;
   localparam logic [1:0]  POL_ONE      = 2'h1;
   localparam logic [1:0]  POL_TWO      = 2'h2;
   localparam logic [1:0]  POL_THREE    = 2'h3;
   // management frame constants
   localparam logic [5:0]  PREAMBLE_LEN = 6'h20;
   localparam logic [1:0]  OP_WRITE     = 2'h1;
   localparam logic [1:0]  OP_READ      = 2'h2;
   localparam logic [4:0]  ADDR_BITS    = 5'h0a;
   localparam logic [4:0]  DATA_BITS    = 5'h10;
   localparam logic [4:0]  TA_BITS      = 5'h02;

   typedef enum logic [2:0]
   {
      MG_PRE, MG_ST, MG_OP, MG_ADDR, MG_TA, MG_DATA
   } scccr_mg_state_t;

   // decoded transmit settings; taps in signed units of 2.5 percent
   typedef struct packed
   {
      logic signed [4:0] post_tap;
      logic signed [3:0] pre_tap;
      logic [3:0]        swing;
   } scccr_tx_cfg_t;

   // routing selections
   typedef struct packed
   {
      logic tx_from_partner;
      logic rx_from_partner;
      logic rx_clk_partner;
      logic rx_clk_is_rx;
   } scccr_route_t;
endpackage

// ### tb/scccr_regs_checker.sv
// assertion checker for the channel config register bank
`timescale 1ns/1ps
`default_nettype none
module scccr_regs_checker
   import scccr_pkg::*;
(
   input wire logic          core_clk_i,
   input wire logic          reset_n_i,
   input wire logic          auto_rate_detect_i,
   input wire logic [3:0]    auto_rate_code_i,
   input wire logic          pattern_verify_i,
   input wire logic          mdio_o,
   input wire logic          mdio_oe_n_o,
   input wire logic [3:0]    pll_factor_code_o,
   input wire logic [6:0]    pll_factor_x4_o,
   input wire logic          pll_code_reserved_o,
   input wire scccr_tx_cfg_t tx_cfg_o,
   input wire scccr_route_t  route_o,
   input wire logic          align_enable_o,
   input wire logic          in_sync_o
);
   // ----
   // factor times four per code, zero when reserved
   // ----
   localparam logic [6:0] X4 [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18,
      7'h20, 7'h21, 7'h28, 7'h30, 7'h00, 7'h3c, 7'h40, 7'h42, 7'h50, 7'h64,
      7'h00};
   logic [1:0] up_q;
   always_ff @(posedge core_clk_i or negedge reset_n_i)
      if (!reset_n_i)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   sequence s_rate_held;
      auto_rate_detect_i && $stable(auto_rate_code_i) && up_q != 2'h0;
   endsequence
   sequence s_ta_drive;
      $fell(mdio_oe_n_o) ##0 !mdio_o;
   endsequence
   a_pll_map: assert property (
      up_q == 2'h3 |-> pll_factor_x4_o == X4[pll_factor_code_o] &&
      pll_code_reserved_o == (X4[pll_factor_code_o] == 7'h00))
      else $error("pll factor mismatch");
   a_rate_override: assert property (
      s_rate_held ##1 s_rate_held |=>
      pll_factor_code_o == $past(auto_rate_code_i))
      else $error("rate sense code not taken");
   a_align_force: assert property (
      (up_q != 2'h0 && pattern_verify_i) [*2] |=> align_enable_o)
      else $error("alignment not forced on");
   a_clk_pair: assert property (
      route_o.rx_clk_partner == route_o.rx_from_partner)
      else $error("rx clock side differs from rx data side");
   a_post_range: assert property (
      tx_cfg_o.post_tap != 5'h10)
      else $error("post tap out of range");
   a_pre_range: assert property (
      tx_cfg_o.pre_tap != 4'h8)
      else $error("pre tap out of range");
   a_ta_hold: assert property (
      s_ta_drive |-> !mdio_oe_n_o [*8])
      else $error("read drive too short");
   a_sync_align: assert property (
      !align_enable_o [*4] |-> !in_sync_o)
      else $error("in sync without alignment");
endmodule
bind scccr_regs scccr_regs_checker u_chk (.*);
`default_nettype wire

// ### tb/scccr_mgmt_host.sv
// management host model on the serial management pins
`timescale 1ns/1ps
`default_nettype none
module scccr_mgmt_host
(
   input  wire logic   clk_i,
   input  wire logic   dev_mdio_i,
   input  wire logic   dev_oe_n_i,
   output logic        mdc_o,
   output logic        mdio_o,
   output logic        rd_v_o,
   output logic [15:0] rd_d_o
);
   localparam logic [1:0] OP_READ_C = 2'h2;
   logic drv;
   logic bit_v;
   // pin level, pulled up when nobody drives
   assign mdio_o = !dev_oe_n_i ? dev_mdio_i : (drv ? bit_v : 1'b1);
   initial
   begin
      {mdc_o, drv, bit_v, rd_v_o} = 4'h2;
      rd_d_o = 16'h0000;
   end
   // whole frames only, preamble each time, clock stopped between
   task automatic frame(input logic [1:0] op, input logic [4:0] ph,
                        input logic [4:0] ra, input logic [15:0] wd);
      logic [63:0] f;
      f = {32'hffffffff, 2'h1, op, ph, ra, 2'h2, wd};
      for (int i = 63; i >= 0; i--)
      begin
         @(posedge clk_i);
         drv <= !(op == OP_READ_C && i < 18);
         bit_v <= f[i];
         repeat (4) @(posedge clk_i);
         if (i < 16)
            rd_d_o <= {rd_d_o[14:0], mdio_o};
         mdc_o <= 1'b1;
         repeat (4) @(posedge clk_i);
         mdc_o <= 1'b0;
      end
      @(posedge clk_i);
      rd_v_o <= (op == OP_READ_C);
      // let go of the line so the pull-up shows between frames
      drv    <= 1'b0;
      @(posedge clk_i);
      rd_v_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/scccr_regs_tb_top.sv
// testbench for the channel config register bank
`timescale 1ns/1ps
`default_nettype none
module scccr_regs_tb_top
   import scccr_pkg::*;
   ;
   localparam logic [4:0]  PHY = 5'h05;
   localparam logic [15:0] W2 [3] = '{16'hff7f, 16'h108a, 16'h0ff0};
   localparam logic [6:0]  X4 [16] = '{7'h00, 7'h00, 7'h10, 7'h14, 7'h18,
      7'h20, 7'h21, 7'h28, 7'h30, 7'h00, 7'h3c, 7'h40, 7'h42, 7'h50, 7'h64,
      7'h00};
   logic          clk, rst_n, mdc, mdio, ard, pvf, pv, hv, dmdio, doe_n;
   logic          rsv, aen, isy;
   logic [3:0]    arc, ev, code;
   logic [6:0]    x4;
   logic [2:0]    s;
   logic [15:0]   pd, hd, got, e, w;
   logic [15:0]   exp_q [$];
   logic [31:0]   seed;
   int            err_total, check_count;
   scccr_tx_cfg_t txc;
   scccr_route_t  rte;
   scccr_regs u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .mdc_i(mdc),
      .mdio_i(mdio), .phy_addr_i(PHY), .auto_rate_detect_i(ard),
      .auto_rate_code_i(arc), .pattern_verify_i(pvf), .code_valid_i(ev[0]),
      .code_error_i(ev[1]), .std_sync_lost_i(ev[2]),
      .sync_acquired_i(ev[3]), .mdio_o(dmdio), .mdio_oe_n_o(doe_n),
      .pll_factor_code_o(code), .pll_factor_x4_o(x4),
      .pll_code_reserved_o(rsv), .tx_cfg_o(txc), .route_o(rte),
      .align_enable_o(aen), .in_sync_o(isy));
   scccr_mgmt_host u_host (.clk_i(clk), .dev_mdio_i(dmdio),
      .dev_oe_n_i(doe_n), .mdc_o(mdc), .mdio_o(mdio), .rd_v_o(hv),
      .rd_d_o(hd));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ----
   // helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [4:0] tap5(input logic [4:0] c);
      return c[4] ? 5'h00 - {1'b0, c[3:0]} : {1'b0, c[3:0]};
   endfunction
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      u_host.frame(OP_WRITE, PHY, ra, d);
      idle(4);
   endtask
   task automatic rd(input logic [4:0] ph, input logic [4:0] ra,
                     input logic [15:0] x);
      exp_q.push_back(x);
      u_host.frame(OP_READ, ph, ra, 16'h0000);
      idle(4);
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      exp_q.push_back(x);
      @(negedge clk);
      pd <= g;
      pv <= 1'b1;
      @(negedge clk);
      pv <= 1'b0;
   endtask
   task automatic pulse(input logic [3:0] k, input int n);
      repeat (n)
      begin
         @(posedge clk);
         ev <= k;
      end
      @(posedge clk);
      ev <= 4'h0;
      idle(4);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----
   // result watcher
   // ----
   always @(posedge clk)
   begin
      if (pv || hv)
      begin
         got = pv ? pd : hd;
         check_count++;
         e = (exp_q.size() != 0) ? exp_q.pop_front() : ~got;
         if (got !== e)
         begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
         end
      end
   end
   initial
   begin
      repeat (90000) @(posedge clk);
      err_total++;
      results();
   end
   // ----
   // main sequence
   // ----
   initial
   begin
      {rst_n, ard, pvf, pv} = 4'h0;
      {arc, ev, pd} = 24'h000000;
      {err_total, check_count} = 64'h0;
      seed = 32'h6ecc;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      idle(4);
      chk({code, 4'h0, x4, rsv}, {4'hd, 4'h0, 7'h50, 1'b0});
      chk({3'h0, txc}, TX_EQ_SWING_RST);
      chk({10'h0, rte, aen, doe_n}, 16'h0007);
      rd(PHY, REG_TX_EQ_SWING, TX_EQ_SWING_RST);
      rd(PHY, REG_SYNC_ROUTE, SYNC_ROUTE_RST);
      rd(PHY, REG_CTRL1, 16'h000d);
      $display("test reset done");
      for (int i = 0; i < 5; i++)
      begin
         seed = lfsr(seed);
         w = (i < 3) ? W2[i] : seed[15:0];
         wr(REG_TX_EQ_SWING, w);
         chk({3'h0, txc}, {3'h0, tap5(w[12:8]),
            4'(tap5({w[7], 1'b0, w[6:4]})), w[3:0]});
         rd(PHY, REG_TX_EQ_SWING, w & 16'h1fff);
      end
      $display("test taps done");
      for (int c = 0; c < 16; c++)
      begin
         @(posedge clk);
         ard <= 1'b1;
         arc <= 4'(c);
         idle(4);
         chk({code, 4'h0, x4, rsv},
            {4'(c), 4'h0, X4[c], X4[c] == 7'h00});
      end
      rd(PHY, REG_CTRL1, 16'h000f);
      @(posedge clk);
      ard <= 1'b0;
      wr(REG_CTRL1, 16'h0005);
      chk({code, 4'h0, x4, rsv}, {4'h5, 4'h0, 7'h20, 1'b0});
      $display("test pll done");
      for (int b = 0; b < 8; b++)
      begin
         s = 3'(b);
         wr(REG_SYNC_ROUTE, {5'h1c, s, 8'hff});
         chk({12'h0, rte}, {12'h0, s[2], s[1], s[1], s[0]});
         rd(PHY, REG_SYNC_ROUTE, {5'h00, s, 8'h80});
      end
      $display("test routing done");
      for (int p = 0; p < 4; p++)
      begin
         wr(REG_SYNC_ROUTE, {3'h0, 2'(p), 11'h180});
         pulse(4'h8, 1);
         pulse(4'h2, p == 0 ? 3 : p - 1);
         pulse(4'h1, 1);
         chk({15'h0, isy}, 16'h0001);
         pulse(p == 0 ? 4'h4 : 4'h2, p == 0 ? 1 : p);
         chk({15'h0, isy}, 16'h0000);
      end
      wr(REG_SYNC_ROUTE, 16'h0800);
      pulse(4'h8, 1);
      chk({14'h0, aen, isy}, 16'h0000);
      @(posedge clk);
      pvf <= 1'b1;
      pulse(4'h8, 1);
      chk({14'h0, aen, isy}, 16'h0003);
      pulse(4'h2, 1);
      chk({15'h0, isy}, 16'h0000);
      $display("test sync done");
      rd(PHY, 5'h04, 16'h0000);
      rd(5'h06, REG_SYNC_ROUTE, 16'hffff);
      // a write to another device address must not land here
      u_host.frame(OP_WRITE, 5'h06, REG_TX_EQ_SWING, ~w);
      idle(4);
      rd(PHY, REG_TX_EQ_SWING, w & 16'h1fff);
      $display("test refusals done");
      if (exp_q.size() != 0)
         err_total++;
      results();
   end
endmodule
`default_nettype wire
